// ===== rtl/cmx_clock_mux.sv
// How it works
// - two three-level straps per bank pick the output format, fixed by wiring.
// - open/open LVPECL, low/low LVDS, high/open HCSL, low/open CML, open/high LP.
// - each strap reads low, high, or a distinct open state.
// - other strap codes give CMOS; 0/1 strongest, then 1/0, 1/1, open/0 weakest.
// - glitch-free switching for clocks 1 to 725 MHz within ten times; here a clock faster than half of the 40 MHz clk aliases.
// - after a select change, follow old clock two to three falls, then low.
// - stay low two to three falls of the new clock.
// - restart on first new-clock rising edge after both phases, never a runt.
// - absent new clock: hold output low until its edges arrive.
// - switching away from an absent clock is also glitch-free; here only a clock stopped low is left, one stopped high keeps draining.
// - output enables sampled on falling edges of the input clock.
// - disabled differential output: true low, complement high.
// - disabled single-ended output: both pins low.
// - an enable left unconnected counts as asserted.
// - select low follows clock a, select high follows clock b.
// - enable high passes the clock, low forces disabled levels.
// - enable changes take effect at the next falling edge; a select change hands over at the second falling edge of the old clock.
//
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module cmx_clock_mux
  import cmx_pkg::*;
#(
  parameter int ABSENT_CYCLES = ABSENT_CYC  // old-clock silence before it counts as absent
) (
  input  wire logic                 clk,           // system clock, 40 MHz
  input  wire logic                 sys_rst,       // async reset, active high
  input  wire logic                 ref_clock_a,   // first reference clock, sampled
  input  wire logic                 ref_clock_b,   // second reference clock, sampled
  input  cmx_fmt_strap_s            format_strap_a, // bank a format straps
  input  cmx_fmt_strap_s            format_strap_b, // bank b format straps
  input  wire logic                 hsel,          // ahb slave select
  input  wire logic [31:0]          haddr,         // ahb address
  input  wire logic [1:0]           htrans,        // ahb transfer type
  input  wire logic                 hwrite,        // ahb write flag
  input  wire logic [2:0]           hsize,         // ahb size, word only
  input  wire logic [31:0]          hwdata,        // ahb write data
  input  wire logic                 hready,        // ahb bus ready
  output logic [31:0]               hrdata,        // ahb read data
  output logic                      hreadyout,     // always ready
  output logic                      hresp,         // always okay
  output cmx_out_s [NUM_CH-1:0]     clk_out_channel // channel output pairs
);

  // =====================================================================
  // format straps, one decode per bank
  cmx_fmt_strap_s bankStrap [NUM_BANKS];
  cmx_fmt_e       bankFmt   [NUM_BANKS];
  logic           bankDiff  [NUM_BANKS];

  assign bankStrap[0] = format_strap_a;
  assign bankStrap[1] = format_strap_b;

  // an unused strap code of 2'h3 is treated as open
  function automatic cmx_strap_e strapLevel(input cmx_strap_e s);
    strapLevel = (s == STRAP_LOW || s == STRAP_HIGH) ? s : STRAP_OPEN;
  endfunction : strapLevel

  function automatic cmx_fmt_e decodeFmt(input cmx_fmt_strap_s s);
    cmx_strap_e b1;
    cmx_strap_e b0;
    b1 = strapLevel(s.bit1);
    b0 = strapLevel(s.bit0);
    unique case ({b1, b0})
      {STRAP_OPEN, STRAP_OPEN}: decodeFmt = FMT_LVPECL;
      {STRAP_LOW,  STRAP_LOW }: decodeFmt = FMT_LVDS;
      {STRAP_HIGH, STRAP_OPEN}: decodeFmt = FMT_HCSL;
      {STRAP_LOW,  STRAP_OPEN}: decodeFmt = FMT_CML;
      {STRAP_OPEN, STRAP_HIGH}: decodeFmt = FMT_LVPECL_LP;
      {STRAP_LOW,  STRAP_HIGH}: decodeFmt = FMT_CMOS_D3;
      {STRAP_HIGH, STRAP_LOW }: decodeFmt = FMT_CMOS_D2;
      {STRAP_HIGH, STRAP_HIGH}: decodeFmt = FMT_CMOS_D1;
      default:                  decodeFmt = FMT_CMOS_D0;
    endcase
  endfunction : decodeFmt

  // codes below the first single-ended code drive a true complement
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    assign bankFmt[b]  = decodeFmt(bankStrap[b]);
    assign bankDiff[b] = (bankFmt[b] < FMT_CMOS_D3);
  end

  // =====================================================================
  // register bus, zero wait states, every response okay
  logic        ctrlSel_q;
  logic [9:0]  oeReg_q;
  logic        wrPend_q;
  logic [7:0]  wrAddr_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [9:0]  oeSync;
  wire         busActive = hsel & hready & htrans[1];
  wire         busRead   = busActive & ~hwrite;
  wire         busWrite  = busActive & hwrite;
  wire  [7:0]  busOff    = {haddr[7:2], 2'b00};
  wire         wrCtrl    = wrPend_q & (wrAddr_q == OFF_CTRL);
  wire         wrOe      = wrPend_q & (wrAddr_q == OFF_OE);

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // write address caught in the address phase, data in the data phase
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
    end else begin
      wrPend_q <= busWrite;
      wrAddr_q <= busOff;
    end
  end

  // enables reset to all ones so an untouched channel runs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrlSel_q <= CTRL_RST;
      oeReg_q   <= OE_RST;
    end else begin
      if (wrCtrl) ctrlSel_q <= hwdata[CTRL_SEL_BIT];
      if (wrOe)   oeReg_q   <= hwdata[9:0];
    end
  end

  // =====================================================================
  // edge detection on the sampled reference clocks
  // a clock faster than half of clk aliases here, a known limit of the sampled mux
  logic prevA_q;
  logic prevB_q;
  logic curSel_q;
  cmx_sw_state_e state_q;
  cmx_sw_state_e state_d;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prevA_q <= 1'b0;
      prevB_q <= 1'b0;
    end else begin
      prevA_q <= ref_clock_a;
      prevB_q <= ref_clock_b;
    end
  end

  wire fallA   = prevA_q & ~ref_clock_a;
  wire fallB   = prevB_q & ~ref_clock_b;
  wire riseA   = ~prevA_q & ref_clock_a;
  wire riseB   = ~prevB_q & ref_clock_b;
  wire srcLvl  = curSel_q ? ref_clock_b : ref_clock_a;
  wire fallCur = curSel_q ? fallB : fallA;
  wire riseCur = curSel_q ? riseB : riseA;

  // =====================================================================
  // switch sequencer: drain old clock, wait on new clock, reopen on a rise
  logic [1:0]       edgeCnt_q;
  logic [1:0]       edgeCnt_d;
  logic [TMO_W-1:0] tmo_q;
  logic [TMO_W-1:0] tmo_d;
  logic             gateOpen_q;
  logic             gateOpen_d;
  logic             curSel_d;
  wire stRun      = (state_q == ST_RUN);
  wire stDrain    = (state_q == ST_DRAIN);
  wire stWait     = (state_q == ST_WAIT);
  wire selChange  = (ctrlSel_q != curSel_q);
  // only a low old clock is cut, so a source stopped high keeps draining
  wire oldAbsent  = (tmo_q == TMO_W'(ABSENT_CYCLES)) & ~srcLvl;
  wire drainDone  = (fallCur & (edgeCnt_q == DRAIN_FALLS - 2'h1)) | oldAbsent;
  wire reopen     = stWait & (edgeCnt_q == WAIT_FALLS) & riseCur;
  // gate opens in the same cycle as the rise so the first high is whole
  wire muxOut     = srcLvl & (gateOpen_q | reopen);

  always_comb begin
    state_d    = state_q;
    edgeCnt_d  = edgeCnt_q;
    tmo_d      = tmo_q;
    gateOpen_d = gateOpen_q;
    curSel_d   = curSel_q;
    unique case (state_q)
      ST_RUN: begin
        if (selChange) begin
          state_d   = ST_DRAIN;
          edgeCnt_d = 2'h0;
          tmo_d     = '0;
        end
      end
      ST_DRAIN: begin
        // keep passing the old clock, close only while it is low
        tmo_d = fallCur ? '0 : (oldAbsent ? tmo_q : tmo_q + TMO_W'(1));
        if (drainDone) begin
          state_d    = ST_WAIT;
          gateOpen_d = 1'b0;
          curSel_d   = ~curSel_q;
          edgeCnt_d  = 2'h0;
        end else if (fallCur) begin
          edgeCnt_d = edgeCnt_q + 2'h1;
        end
      end
      ST_WAIT: begin
        // no timeout here: a silent new clock keeps the output low
        if (reopen) begin
          state_d    = ST_RUN;
          gateOpen_d = 1'b1;
        end else if (fallCur && edgeCnt_q != WAIT_FALLS) begin
          edgeCnt_d = edgeCnt_q + 2'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q    <= ST_RUN;
      edgeCnt_q  <= 2'h0;
      tmo_q      <= '0;
      gateOpen_q <= 1'b1;
      curSel_q   <= CTRL_RST;
    end else begin
      state_q    <= state_d;
      edgeCnt_q  <= edgeCnt_d;
      tmo_q      <= tmo_d;
      gateOpen_q <= gateOpen_d;
      curSel_q   <= curSel_d;
    end
  end

  // =====================================================================
  // output channels, five to a bank, each with its own enable
  // every channel shares the gated mux; only the enable and the bank format differ per channel
  for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
    cmx_out_stage u_stage (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .srcLevel (muxOut),
      .fallEdge (fallCur),
      .enReq    (oeReg_q[c]),
      .isDiff   (bankDiff[c / BANK_CH]),
      .enSync   (oeSync[c]),
      .outPair  (clk_out_channel[c])
    );
  end

  // =====================================================================
  // read mux, registered in the address phase; unmapped reads give zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (busOff)
      OFF_CTRL:   rdata_d[CTRL_SEL_BIT] = ctrlSel_q;
      OFF_OE:     rdata_d[9:0] = oeReg_q;
      OFF_STATUS: begin
        rdata_d[STAT_SEL_BIT] = curSel_q;
        rdata_d[STAT_ST_LSB +: 3] = state_q;
        rdata_d[STAT_GATE_BIT] = gateOpen_q;
      end
      OFF_FORMAT: begin
        rdata_d[3:0] = bankFmt[0];
        rdata_d[FMT_B_LSB +: 4] = bankFmt[1];
      end
      OFF_OESYNC: rdata_d[9:0] = oeSync;
      default:    rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (busRead) begin
      rdata_q <= rdata_d;
    end
  end

  // =====================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_drain_done;
    stDrain && fallCur && edgeCnt_q == 2'h1;
  endsequence

  sequence s_wait_ready;
    stWait && edgeCnt_q == 2'h2 && riseCur;
  endsequence

  // the close of the old clock and the second new-clock fall, as single steps
  sequence s_old_closed;
    stDrain && drainDone;
  endsequence

  sequence s_new_counted;
    stWait && fallCur && edgeCnt_q == 2'h1;
  endsequence

  a_sel_starts_drain: assert property (stRun && selChange |=> stDrain)
    else $error("select change did not start draining");
  a_drain_two_falls: assert property (s_drain_done |=> stWait && !gateOpen_q && curSel_q != $past(curSel_q))
    else $error("drain did not close after two falls");
  a_wait_held_low: assert property (stWait |-> !gateOpen_q)
    else $error("gate open while waiting on new clock");
  a_restart_rise: assert property (s_wait_ready |-> muxOut ##1 stRun && gateOpen_q)
    else $error("output did not restart on first rise");
  a_no_runt_rise: assert property ($rose(muxOut) |-> $rose(srcLvl) && $stable(curSel_q))
    else $error("output rose without a clock rise");
  a_no_runt_fall: assert property ($fell(muxOut) |-> $fell(srcLvl) && $stable(curSel_q))
    else $error("output fell without a clock fall");
  a_absent_hold: assert property (stWait && !fallCur && !riseCur |=> stWait)
    else $error("left wait without new clock edges");
  a_sel_follows: assert property (stRun && gateOpen_q |-> muxOut == (ctrlSel_q ? ref_clock_b : ref_clock_a)
                                  || selChange)
    else $error("output not following selected clock");
  a_format_lvds: assert property (format_strap_a == cmx_fmt_strap_s'{bit1: STRAP_LOW, bit0: STRAP_LOW}
                                  |-> bankFmt[0] == FMT_LVDS)
    else $error("low/low strap not decoded as lvds");
  a_format_cmos: assert property (format_strap_b == cmx_fmt_strap_s'{bit1: STRAP_LOW, bit0: STRAP_HIGH}
                                  |-> bankFmt[1] == FMT_CMOS_D3 && !bankDiff[1])
    else $error("0/1 strap not strongest cmos");
  a_open_distinct: assert property (format_strap_a == cmx_fmt_strap_s'{bit1: STRAP_OPEN, bit0: STRAP_OPEN}
                                    |-> bankFmt[0] == FMT_LVPECL)
    else $error("open straps not seen as open");

  a_drain_keeps_old: assert property (stDrain && !drainDone |=> $stable(curSel_q) && gateOpen_q)
    else $error("old clock cut before its falls");
  a_close_starts_wait: assert property (s_old_closed |=> stWait && edgeCnt_q == 2'h0)
    else $error("close did not start the new-clock count");
  a_wait_first_fall: assert property (stWait && fallCur && edgeCnt_q == 2'h0 |=> stWait && edgeCnt_q == 2'h1)
    else $error("first new-clock fall not counted");
  a_wait_second_fall: assert property (s_new_counted |=> stWait && edgeCnt_q == 2'h2)
    else $error("second new-clock fall not counted");
  a_absent_old_ends: assert property (stDrain && oldAbsent |=> stWait)
    else $error("drain stuck on an absent old clock");
  a_wait_output_low: assert property (stWait && !reopen |-> !muxOut)
    else $error("output high while waiting on new clock");

  // format decode spot checks for three more kinds of strap row
  a_format_hcsl: assert property (format_strap_a == cmx_fmt_strap_s'{bit1: STRAP_HIGH, bit0: STRAP_OPEN}
                                  |-> bankFmt[0] == FMT_HCSL && bankDiff[0])
    else $error("high/open strap not decoded as hcsl");
  a_format_low_power: assert property (format_strap_b == cmx_fmt_strap_s'{bit1: STRAP_OPEN, bit0: STRAP_HIGH}
                                       |-> bankFmt[1] == FMT_LVPECL_LP && bankDiff[1])
    else $error("open/high strap not decoded as low power");
  a_format_weakest: assert property (format_strap_a == cmx_fmt_strap_s'{bit1: STRAP_OPEN, bit0: STRAP_LOW}
                                     |-> bankFmt[0] == FMT_CMOS_D0 && !bankDiff[0])
    else $error("open/low strap not weakest cmos");

endmodule : cmx_clock_mux

// ===== rtl/cmx_out_stage.sv
`timescale 1ns/1ps
module cmx_out_stage
  import cmx_pkg::*;
(
  input  wire logic     clk,       // system clock
  input  wire logic     sys_rst,   // async reset, active high
  input  wire logic     srcLevel,  // gated mux clock level
  input  wire logic     fallEdge,  // falling edge of active clock
  input  wire logic     enReq,     // software enable request
  input  wire logic     isDiff,    // bank uses a differential format
  output logic          enSync,    // enable as applied
  output cmx_out_s      outPair    // true and complement pins
);

  logic     enSync_q;
  cmx_out_s out_q;
  cmx_out_s out_d;

  // =====================================================================
  // enable only moves on a falling edge, so the clock is low when it does
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enSync_q <= 1'b1;
    end else if (fallEdge) begin
      enSync_q <= enReq;
    end
  end

  // disabled levels depend on format, enabled output ignores format
  assign out_d.tru  = enSync_q & srcLevel;
  assign out_d.comp = enSync_q ? ~srcLevel : isDiff;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_q <= '{tru: 1'b0, comp: 1'b0};
    end else begin
      out_q <= out_d;
    end
  end

  assign enSync  = enSync_q;
  assign outPair = out_q;

  // =====================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_oe_fall_only: assert property (!fallEdge |=> $stable(enSync_q))
    else $error("enable changed without a falling edge");
  a_diff_disabled: assert property (!enSync_q && isDiff |=> out_q.tru == 1'b0 && out_q.comp == 1'b1)
    else $error("disabled differential output not low/high");
  a_cmos_disabled: assert property (!enSync_q && !isDiff |=> out_q.tru == 1'b0 && out_q.comp == 1'b0)
    else $error("disabled single-ended output not low/low");

endmodule : cmx_out_stage

// ===== rtl/cmx_pkg.sv
package cmx_pkg;

  // =====================================================================
  // geometry
  localparam int NUM_CH     = 10;
  localparam int BANK_CH    = 5;
  localparam int NUM_BANKS  = 2;

  // =====================================================================
  // timing: system clock and absent-clock detection
  localparam int SYS_CLK_MHZ     = 40;
  localparam int ABSENT_TIME_NS  = 2000;  // two periods of the slowest legal clock
  localparam int ABSENT_CYC      = (ABSENT_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int TMO_W           = $clog2(ABSENT_CYC + 1);
  localparam logic [1:0] DRAIN_FALLS = 2'h2;
  localparam logic [1:0] WAIT_FALLS  = 2'h2;

  // =====================================================================
  // register map, byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_OE     = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_FORMAT = 8'h0C;
  localparam logic [7:0] OFF_OESYNC = 8'h10;
  localparam int CTRL_SEL_BIT   = 0;
  localparam int STAT_SEL_BIT   = 0;
  localparam int STAT_ST_LSB    = 1;
  localparam int STAT_GATE_BIT  = 4;
  localparam int FMT_B_LSB      = 4;
  localparam logic       CTRL_RST = 1'h0;
  localparam logic [9:0] OE_RST   = 10'h3FF;

  // =====================================================================
  // types
  typedef enum logic [1:0] {
    STRAP_LOW  = 2'h0,
    STRAP_HIGH = 2'h1,
    STRAP_OPEN = 2'h2
  } cmx_strap_e;

  typedef struct packed {
    cmx_strap_e bit1;
    cmx_strap_e bit0;
  } cmx_fmt_strap_s;

  typedef enum logic [3:0] {
    FMT_LVPECL    = 4'h0,
    FMT_LVDS      = 4'h1,
    FMT_HCSL      = 4'h2,
    FMT_CML       = 4'h3,
    FMT_LVPECL_LP = 4'h4,
    FMT_CMOS_D3   = 4'h5,
    FMT_CMOS_D2   = 4'h6,
    FMT_CMOS_D1   = 4'h7,
    FMT_CMOS_D0   = 4'h8
  } cmx_fmt_e;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_DRAIN = 3'b010,
    ST_WAIT  = 3'b100
  } cmx_sw_state_e;

  typedef struct packed {
    logic tru;
    logic comp;
  } cmx_out_s;

endpackage : cmx_pkg

// ===== sim/cmx_ref_src.sv
`timescale 1ns/1ps
// =====================================================================
// reference clock sources
module cmx_ref_src #(
  parameter realtime HALF_A = 155.0,  // half period of source a, about 3.2 MHz
  parameter realtime HALF_B = 230.0   // half period of source b, about 2.2 MHz
) (
  input  wire logic runA,  // source a running
  input  wire logic runB,  // source b running
  output logic      refA,  // clock a level
  output logic      refB   // clock b level
);
  // odd start offsets keep every edge clear of the sampling clock edges;
  // a stopped source finishes its high half and then stands low
  initial begin
    refA = 1'b0;
    #3.7;
    forever begin
      #(HALF_A);
      if (runA || refA) refA = ~refA;
    end
  end

  // second source, within a factor of ten of the first
  initial begin
    refB = 1'b0;
    #1.3;
    forever begin
      #(HALF_B);
      if (runB || refB) refB = ~refB;
    end
  end
endmodule : cmx_ref_src

// ===== sim/tb_top.sv
`timescale 1ns/1ps
// =====================================================================
// signals
module tb_top
  import cmx_pkg::*;
;
  localparam int MIN_RUN = 6;     // shortest sampled half period of either source
  localparam int GAP     = 4700;  // about 255 periods of the slower source, in clk cycles
  localparam logic [3:0] STRAPS [10] = '{4'hA, 4'h0, 4'h6, 4'h2, 4'h9, 4'h1, 4'h4, 4'h5, 4'h8, 4'hF};
  localparam logic [3:0] FMTS   [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h0};

  logic                 clk     = 1'b0;
  logic                 sysRst  = 1'b1;
  logic                 runA    = 1'b1;
  logic                 runB    = 1'b1;
  logic                 hsel    = 1'b0;
  logic                 hwrite  = 1'b0;
  logic [1:0]           htrans  = 2'h0;
  logic [2:0]           hsize   = 3'h2;
  logic [31:0]          haddr   = 32'h0;
  logic [31:0]          hwdata  = 32'h0;
  cmx_fmt_strap_s       strapA  = cmx_fmt_strap_s'(4'hA);
  cmx_fmt_strap_s       strapB  = cmx_fmt_strap_s'(4'h0);
  logic [31:0]          hrdata;
  logic                 hreadyout;
  logic                 hresp;
  cmx_out_s [NUM_CH-1:0] chOut;
  logic                 refA;
  logic                 refB;
  wire  [1:0]           refNow  = {refB, refA};
  logic [1:0]           refPrev = 2'h0;
  logic                 outPrev = 1'b0;
  logic                 monOn   = 1'b0;
  int                   runLen, outRise, failCount, totalChecks;
  int                   fallCnt [2];
  int                   riseCnt [2];
  int                   otherAtFall [2];

  always #12.5 clk = ~clk;

  // absent timeout above the slower source period so a live drain is never cut short
  cmx_clock_mux #(.ABSENT_CYCLES(40)) i_dut (
    .clk(clk), .sys_rst(sysRst), .ref_clock_a(refA), .ref_clock_b(refB),
    .format_strap_a(strapA), .format_strap_b(strapB), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .clk_out_channel(chOut));

  cmx_ref_src i_src (.runA(runA), .runB(runB), .refA(refA), .refB(refB));

  // =====================================================================
  // tasks
  task automatic fail(input string msg);
    failCount++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask : fail

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    totalChecks++;
    if (got !== exp) fail($sformatf("%s got %h expected %h", msg, got, exp));
  endtask : chk

  task automatic finalReport;
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finalReport

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // one single word; each phase held until hready is seen high
  task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                          output logic [31:0] rdv);
    haddr  <= {24'h0, a};
    hwrite <= wr;
    hsize  <= 3'h2;
    htrans <= 2'h2;
    hsel   <= 1'b1;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wr ? wd : 32'h0;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask : ahb_xfer

  // bounded poll, so a stuck switch state is reported rather than hung on
  task automatic wait_status(input logic [31:0] mask, input logic [31:0] exp, input string msg);
    logic [31:0] d;
    int n;
    n = 0;
    do begin
      ahb_xfer(1'b0, OFF_STATUS, 32'h0, d);
      n++;
    end while ((d & mask) !== exp && n < 400);
    chk(d & mask, exp, msg);
  endtask : wait_status

  // channel 0 must show as many rising edges as the selected source, to within one
  task automatic follow_check(input int k);
    int r0, o0;
    r0 = riseCnt[k];
    o0 = outRise;
    cyc(400);
    totalChecks++;
    if ((riseCnt[k] - r0) - (outRise - o0) > 1 || (outRise - o0) - (riseCnt[k] - r0) > 1)
      fail("channel 0 does not follow the selected clock");
  endtask : follow_check

  // =====================================================================
  // monitors: source edges and channel 0 pulse widths, sampled like the design
  always @(posedge clk) begin
    for (int k = 0; k < 2; k++) begin
      if (refPrev[k] && !refNow[k]) begin
        fallCnt[k]++;
        otherAtFall[k] = fallCnt[1-k];
      end
      if (!refPrev[k] && refNow[k]) riseCnt[k]++;
    end
    refPrev = refNow;
    if (chOut[0].tru !== outPrev) begin
      if (monOn) totalChecks++;
      if (monOn && runLen < MIN_RUN) fail("short pulse on channel 0");
      if (chOut[0].tru === 1'b1) outRise++;
      runLen = 0;
    end
    runLen++;
    outPrev = chOut[0].tru;
  end

  // hang guard, well past the expected run of about 16000 cycles
  initial begin
    cyc(60000);
    fail("watchdog expired");
    finalReport();
  end

  // =====================================================================
  // tests
  initial begin
    logic [31:0] rd;
    int s0, s1;
    cyc(3);
    sysRst <= 1'b0;
    @(posedge clk);
    // reset values, masking, read-only and unmapped places
    ahb_xfer(1'b0, OFF_CTRL, 32'h0, rd);
    chk(rd, 32'h0, "select after reset");
    ahb_xfer(1'b0, OFF_OE, 32'h0, rd);
    chk(rd, 32'h3FF, "enables after reset");
    ahb_xfer(1'b0, OFF_OESYNC, 32'h0, rd);
    chk(rd, 32'h3FF, "applied enables after reset");
    ahb_xfer(1'b0, OFF_STATUS, 32'h0, rd);
    chk(rd, 32'h12, "status after reset");
    ahb_xfer(1'b1, 8'h20, 32'hFFFFFFFF, rd);
    ahb_xfer(1'b1, OFF_FORMAT, 32'hFFFFFFFF, rd);
    ahb_xfer(1'b1, OFF_CTRL, 32'hFFFFFFFE, rd);
    ahb_xfer(1'b1, OFF_OE, 32'hFFFFFFFF, rd);
    ahb_xfer(1'b0, OFF_CTRL, 32'h0, rd);
    chk(rd, 32'h0, "select field width");
    ahb_xfer(1'b0, 8'h20, 32'h0, rd);
    chk(rd, 32'h0, "unmapped read");
    ahb_xfer(1'b0, OFF_OE, 32'h0, rd);
    chk(rd, 32'h3FF, "enable field width");
    // every strap pair on both banks, the banks decoded apart
    for (int i = 0; i < 10; i++) begin
      strapA <= cmx_fmt_strap_s'(STRAPS[i]);
      strapB <= cmx_fmt_strap_s'(STRAPS[9-i]);
      cyc(2);
      ahb_xfer(1'b0, OFF_FORMAT, 32'h0, rd);
      chk(rd, {24'h0, FMTS[9-i], FMTS[i]}, "format decode");
    end
    strapA <= cmx_fmt_strap_s'(4'h1);
    strapB <= cmx_fmt_strap_s'(4'h0);
    cyc(40);
    monOn <= 1'b1;
    follow_check(0);
    // disable one single-ended and one differential channel
    ahb_xfer(1'b1, OFF_OE, 32'h3BD, rd);
    cyc(40);
    ahb_xfer(1'b0, OFF_OESYNC, 32'h0, rd);
    chk(rd, 32'h3BD, "enables applied");
    repeat (30) begin
      @(posedge clk);
      chk({30'h0, chOut[1]}, 32'h0, "single-ended disabled levels");
      chk({30'h0, chOut[6]}, 32'h1, "differential disabled levels");
    end
    // with the active source stopped no fall arrives, so enables must wait
    runA <= 1'b0;
    cyc(40);
    ahb_xfer(1'b1, OFF_OE, 32'h3FF, rd);
    cyc(30);
    ahb_xfer(1'b0, OFF_OESYNC, 32'h0, rd);
    chk(rd, 32'h3BD, "enable applied without a fall");
    chk({30'h0, chOut[6]}, 32'h1, "output changed without a fall");
    runA <= 1'b1;
    cyc(40);
    ahb_xfer(1'b0, OFF_OESYNC, 32'h0, rd);
    chk(rd, 32'h3FF, "enable applied after falls");
    // live switch from a to b, counting falls of both sources
    cyc(GAP);
    ahb_xfer(1'b1, OFF_CTRL, 32'h1, rd);
    s0 = fallCnt[0];
    wait_status(32'h0E, 32'h08, "drain ends in wait");
    s1 = otherAtFall[0];
    totalChecks++;
    if (fallCnt[0] - s0 < 2 || fallCnt[0] - s0 > 3) fail("old clock falls before stop");
    wait_status(32'h1F, 32'h13, "running on clock b");
    totalChecks++;
    if (fallCnt[1] - s1 < 2 || fallCnt[1] - s1 > 3) fail("new clock falls while low");
    follow_check(1);
    // switch to an absent source: output stops low and waits
    cyc(GAP);
    runA <= 1'b0;
    cyc(20);
    ahb_xfer(1'b1, OFF_CTRL, 32'h0, rd);
    wait_status(32'h0E, 32'h08, "waiting for absent clock");
    repeat (200) begin
      @(posedge clk);
      chk({31'h0, chOut[0].tru}, 32'h0, "output low while clock absent");
    end
    runA <= 1'b1;
    wait_status(32'h1F, 32'h12, "running on returned clock a");
    // switch away from a source that has stopped
    cyc(GAP);
    runA <= 1'b0;
    cyc(20);
    ahb_xfer(1'b1, OFF_CTRL, 32'h1, rd);
    wait_status(32'h1F, 32'h13, "switch away from absent clock");
    runA <= 1'b1;
    cyc(100);
    finalReport();
  end
endmodule : tb_top
